// ===== core/realign_pkg.sv
package realign_pkg;
    // deserialization widths the realigner accepts
    localparam int WORD_W_DEF = 10;
    localparam int WORD_W_ALT = 8;
    localparam int NUM_CH_DEF = 4;
    localparam int FIFO_DEPTH_DEF = 16;
    // slip counter: wide enough for a count of WORD_W_DEF - 1
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    // slip request shape on the global low-speed clock, in cycles
    localparam int SLIP_HIGH_CYC = 2;
    localparam int SLIP_LOW_CYC = 3;
    // words skipped after a slip before the pattern is judged again;
    // covers realigner latency plus a full data fifo
    localparam int SETTLE_WORDS = 24;
    localparam int TMR_W = 5;
    localparam logic [15:0] TRAIN_PAT_DEF = 16'h001f;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_PULSE,
        ST_GAP,
        ST_SETTLE,
        ST_LOCKED
    } align_state_t;
endpackage

// ===== core/realign_if.sv
`timescale 1ns/1ns
interface realign_if
    import realign_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int WORD_W = WORD_W_DEF
);
    logic [NUM_CH*WORD_W-1:0] word;
    logic word_valid;
    logic word_ready;
    logic [NUM_CH-1:0] slip_req;

    modport dev (
        output word,
        output word_valid,
        input word_ready,
        input slip_req
    );

    modport fab (
        input word,
        input word_valid,
        output word_ready,
        output slip_req
    );
endinterface

// ===== core/word_fifo.sv
`timescale 1ns/1ns
module word_fifo
    import realign_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    // one extra pointer bit tells full from empty
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;

    wire empty = (wr_ptr_r == rd_ptr_r);
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW])
        && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

// ===== core/word_realigner.sv
`timescale 1ns/1ns
// Contract
// - realign parallel words after the deserializer
// - one independent realigner per receive channel
// - each request rising edge slips one bit
// - always in path; otherwise pure register latency
// - word width of 8 or 10 bits
// - counter selects bits from older/newer word
// - counter wraps past width-1; newest word only
// - realigned word valid on next low-speed cycle
// - clocked by the global low-speed clock
// - request from fabric logic or pin
// - fabric slips again after each pattern mismatch
// - fabric registers incoming words before comparing
// - fabric registers slip request before driving it
// - slip request high for two cycles
// - slip request low three cycles between pulses
module word_realigner
    import realign_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int WORD_W = WORD_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NUM_CH*WORD_W-1:0] deser_word,
    input wire logic deser_valid,
    output logic deser_ready,
    input wire logic slip_enable,
    input wire logic [NUM_CH-1:0] slip_from_pin,
    input wire logic [NUM_CH-1:0] slip_pin,
    input wire logic overflow_clear,
    output logic overflow,
    output logic [NUM_CH*CNT_W-1:0] slip_count,
    realign_if.dev link
);
    // only the two documented widths exist; anything else falls to 10
    localparam int WW = (WORD_W == WORD_W_ALT) ? WORD_W_ALT
        : WORD_W_DEF;
    localparam int BUS_W = NUM_CH * WW;
    localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(WW - 1);
    // the counter never passes CNT_TOP, so four bits cover both widths;
    // a wider word would need a wider CNT_W as well

    // bit 0 of a word is the earliest bit on the wire, so {newer, older}
    // is the stream in arrival order and a window lower by sh bits
    // moves the boundary sh bits earlier
    function automatic logic [WW-1:0] pick_word(
        input logic [WW-1:0] newer,
        input logic [WW-1:0] older,
        input logic [CNT_W-1:0] sh
    );
        logic [2*WW-1:0] both;
        logic [WW-1:0] res;
        both = {newer, older};
        res = '0;
        for (int i = 0; i < WW; i++) begin
            res[i] = both[i + WW - int'(sh)];
        end
        return res;
    endfunction

    function automatic logic [CNT_W-1:0] bump_count(
        input logic [CNT_W-1:0] cnt
    );
        logic [CNT_W-1:0] res;
        res = (cnt == CNT_TOP) ? CNT_RST : cnt + 1'b1;
        return res;
    endfunction

    // pipeline fill: two words must be held before a window is complete
    logic [1:0] fill_r;
    logic [BUS_W-1:0] out_word_r;
    logic out_vld_r;
    logic overflow_r;
    logic fifo_in_ready;
    logic [BUS_W-1:0] fifo_in_word;

    // the counter and edge detector run even while no word arrives,
    // so a slip taken during an input gap applies to the next word
    wire pipe_full = fill_r[1];
    wire take = deser_valid;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fill_r <= 2'h0;
        end else if (take && !pipe_full) begin
            fill_r <= {fill_r[0], 1'b1};
        end
    end

    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        logic [WW-1:0] older_r;
        logic [WW-1:0] newer_r;
        logic [CNT_W-1:0] cnt_r;
        logic [CNT_W-1:0] cnt_nxt;
        logic pin_s1_r;
        logic pin_s2_r;
        logic req_q_r;
        logic req_d_r;

        wire [WW-1:0] in_word = deser_word[g*WW +: WW];
        // the pin comes from outside and is synchronised first
        wire req_src = slip_from_pin[g] ? pin_s2_r
            : link.slip_req[g];
        // a request held high slips once; one low cycle re-arms it,
        // the longer gap is the controlling logic's duty
        wire slip_edge = slip_enable && req_q_r && !req_d_r;
        wire [WW-1:0] aligned = pick_word(newer_r, older_r, cnt_r);

        assign cnt_nxt = slip_edge ? bump_count(cnt_r) : cnt_r;
        assign fifo_in_word[g*WW +: WW] = out_word_r[g*WW +: WW];
        // the count is exposed so the fabric can see the applied offset
        assign slip_count[g*CNT_W +: CNT_W] = cnt_r;

        always_ff @(posedge clk) begin
            if (!nrst) begin
                pin_s1_r <= 1'b0;
                pin_s2_r <= 1'b0;
                req_q_r <= 1'b0;
                req_d_r <= 1'b0;
            end else begin
                pin_s1_r <= slip_pin[g];
                pin_s2_r <= pin_s1_r;
                req_q_r <= req_src;
                req_d_r <= req_q_r;
            end
        end

        // each channel owns its counter and word registers
        always_ff @(posedge clk) begin
            if (!nrst) begin
                cnt_r <= CNT_RST;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end

        // older/newer form the two-word window the counter picks from
        always_ff @(posedge clk) begin
            if (!nrst) begin
                older_r <= '0;
                newer_r <= '0;
            end else if (take) begin
                older_r <= newer_r;
                newer_r <= in_word;
            end
        end

        // with the count at zero this is newer_r unchanged
        always_ff @(posedge clk) begin
            if (!nrst) begin
                out_word_r[g*WW +: WW] <= '0;
            end else if (take) begin
                out_word_r[g*WW +: WW] <= aligned;
            end
        end
    end

    // a new realigned word follows every low-speed cycle with input;
    // nothing is pushed until both window registers have been filled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_vld_r <= 1'b0;
        end else begin
            out_vld_r <= take && pipe_full;
        end
    end

    // the deserializer cannot stall, so a full fifo loses the word;
    // the sticky flag makes that visible, and a new loss beats a clear
    wire lost = out_vld_r && !fifo_in_ready;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            overflow_r <= 1'b0;
        end else if (lost) begin
            overflow_r <= 1'b1;
        end else if (overflow_clear) begin
            overflow_r <= 1'b0;
        end
    end

    // outputs come from registers, fifo storage or decodes of the fifo pointers
    assign overflow = overflow_r;
    assign deser_ready = fifo_in_ready;

    // deser_ready only reports room in the fifo: the realigner keeps
    // shifting words in regardless, since the source cannot wait
    word_fifo #(
        .WIDTH(BUS_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(fifo_in_word),
        .in_valid(out_vld_r),
        .in_ready(fifo_in_ready),
        .out_data(link.word),
        .out_valid(link.word_valid),
        .out_ready(link.word_ready)
    );
endmodule

// ===== core/align_trainer.sv
`timescale 1ns/1ns
module align_trainer
    import realign_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int WORD_W = WORD_W_DEF,
    parameter logic [WORD_W-1:0] TRAIN_PATTERN = WORD_W'(TRAIN_PAT_DEF)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic train_start,
    input wire logic user_ready,
    output logic [NUM_CH*WORD_W-1:0] user_word,
    output logic user_valid,
    output logic [NUM_CH-1:0] locked,
    realign_if.fab link
);
    localparam logic [TMR_W-1:0] HIGH_END = TMR_W'(SLIP_HIGH_CYC - 1);
    localparam logic [TMR_W-1:0] LOW_END = TMR_W'(SLIP_LOW_CYC - 1);
    localparam logic [TMR_W-1:0] SETTLE_END = TMR_W'(SETTLE_WORDS - 1);

    logic [NUM_CH*WORD_W-1:0] in_word_r;
    logic in_vld_r;
    logic [NUM_CH-1:0] slip_req_r;

    wire accept = link.word_valid && user_ready;
    assign link.word_ready = user_ready;
    assign link.slip_req = slip_req_r;
    assign user_word = in_word_r;
    assign user_valid = in_vld_r;

    // words are judged only from this register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_word_r <= '0;
            in_vld_r <= 1'b0;
        end else begin
            in_vld_r <= accept;
            if (accept) begin
                in_word_r <= link.word;
            end
        end
    end

    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        align_state_t st_r;
        align_state_t st_nxt;
        logic [TMR_W-1:0] tmr_r;
        logic [TMR_W-1:0] tmr_nxt;

        wire match = in_word_r[g*WORD_W +: WORD_W] == TRAIN_PATTERN;

        always_comb begin
            st_nxt = st_r;
            tmr_nxt = tmr_r;
            case (st_r)
                ST_IDLE: begin
                    if (train_start) begin
                        st_nxt = ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (in_vld_r) begin
                        tmr_nxt = '0;
                        st_nxt = match ? ST_LOCKED : ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    tmr_nxt = tmr_r + 1'b1;
                    if (tmr_r == HIGH_END) begin
                        tmr_nxt = '0;
                        st_nxt = ST_GAP;
                    end
                end
                ST_GAP: begin
                    tmr_nxt = tmr_r + 1'b1;
                    if (tmr_r == LOW_END) begin
                        tmr_nxt = '0;
                        st_nxt = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // old words still in flight must not be judged
                    if (in_vld_r) begin
                        tmr_nxt = tmr_r + 1'b1;
                        if (tmr_r == SETTLE_END) begin
                            st_nxt = ST_CHECK;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (train_start) begin
                        st_nxt = ST_CHECK;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk) begin
            if (!nrst) begin
                st_r <= ST_IDLE;
                tmr_r <= '0;
                slip_req_r[g] <= 1'b0;
            end else begin
                st_r <= st_nxt;
                tmr_r <= tmr_nxt;
                slip_req_r[g] <= (st_nxt == ST_PULSE);
            end
        end

        assign locked[g] = (st_r == ST_LOCKED);
    end
endmodule

// ===== tb/realign_monitor.sv
`timescale 1ns/1ns
module realign_monitor
    import realign_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int WORD_W = WORD_W_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NUM_CH*WORD_W-1:0] word,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic [NUM_CH-1:0] slip_req
);
    logic [3:0] age_r;
    logic [3:0] age_nxt;
    // saturates so a long idle stretch never looks like a fresh word
    assign age_nxt = (word_valid && word_ready) ? 4'h0 :
        (age_r == 4'hf) ? age_r : age_r + 4'h1;
    always_ff @(posedge clk) begin
        age_r <= nrst ? age_nxt : 4'hf;
    end
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!nrst);
    reset_clear_a: assert property (disable iff (1'b0)
        !nrst |=> !word_valid && slip_req == '0)
        else $error("reset left state");
    fill_wait_a: assert property (
        $rose(nrst) |-> !word_valid [*3])
        else $error("word before pipeline fill");
    quiet_start_a: assert property (
        $rose(nrst) |-> (slip_req == '0) [*4])
        else $error("slip right after reset");
    hold_word_a: assert property (
        word_valid && !word_ready |=> word_valid && $stable(word))
        else $error("word dropped before pop");
    for (genvar g = 0; g < NUM_CH; g++) begin : per_ch
        pulse_two_a: assert property (
            $rose(slip_req[g]) |=> slip_req[g] ##1 !slip_req[g])
            else $error("slip pulse not two cycles");
        gap_three_a: assert property (
            $rose(slip_req[g]) |->
            !$past(slip_req[g], 2) && !$past(slip_req[g], 3))
            else $error("slip gap too short");
        settle_gap_a: assert property (
            $fell(slip_req[g]) |-> !slip_req[g] [*8])
            else $error("slip before settling");
        pop_cause_a: assert property (
            $rose(slip_req[g]) |-> age_r < 4'h6)
            else $error("slip without a judged word");
    end
endmodule

// ===== tb/dpa_word_boundary_realigner_test.sv
`timescale 1ns/1ns
module dpa_word_boundary_realigner_test
    import realign_pkg::*;
;
    localparam int N = NUM_CH_DEF;
    localparam int W = WORD_W_DEF;
    localparam logic [W-1:0] PAT = W'(TRAIN_PAT_DEF);
    // bit misalignment per channel; channel 2 arrives aligned
    localparam int OFS [4] = '{3, 7, 0, 9};
    localparam int LIMIT = 20000;
    logic clk, nrst, deser_valid, deser_ready, slip_enable;
    logic overflow_clear, overflow, train_start, user_ready, user_valid;
    logic [N*W-1:0] deser_word, user_word;
    logic [N-1:0] slip_from_pin, slip_pin, locked;
    logic [N*CNT_W-1:0] slip_count;
    int n_fail, tests_run, cycles;

    realign_if #(.NUM_CH(N), .WORD_W(W)) realign_if_i ();
    word_realigner #(.NUM_CH(N), .WORD_W(W), .FIFO_DEPTH(FIFO_DEPTH_DEF))
        word_realigner_i (.clk(clk), .nrst(nrst), .deser_word(deser_word),
        .deser_valid(deser_valid), .deser_ready(deser_ready),
        .slip_enable(slip_enable), .slip_from_pin(slip_from_pin),
        .slip_pin(slip_pin), .overflow_clear(overflow_clear),
        .overflow(overflow), .slip_count(slip_count),
        .link(realign_if_i.dev));
    align_trainer #(.NUM_CH(N), .WORD_W(W), .TRAIN_PATTERN(PAT))
        align_trainer_i (.clk(clk), .nrst(nrst), .train_start(train_start),
        .user_ready(user_ready), .user_word(user_word),
        .user_valid(user_valid), .locked(locked), .link(realign_if_i.fab));
    realign_monitor #(.NUM_CH(N), .WORD_W(W)) realign_monitor_i (
        .clk(clk), .nrst(nrst), .word(realign_if_i.word),
        .word_valid(realign_if_i.word_valid),
        .word_ready(realign_if_i.word_ready),
        .slip_req(realign_if_i.slip_req));

    // a word boundary k bits late shows as the pattern rotated by k
    function automatic logic [W-1:0] rot(input int k);
        logic [W-1:0] r;
        for (int i = 0; i < W; i++) begin
            r[i] = PAT[(i + k) % W];
        end
        return r;
    endfunction
    function automatic logic [15:0] cnt(input int g);
        return 16'(slip_count[g*CNT_W +: CNT_W]);
    endfunction
    function automatic logic [15:0] uw(input int g);
        return 16'(user_word[g*W +: W]);
    endfunction

    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // the pin path has two sync flops, so the low tail waits them out
    task automatic pin_pulse(input int hi);
        slip_pin[0] = 1'b1;
        tick(hi);
        slip_pin[0] = 1'b0;
        tick(4);
    endtask
    task automatic train();
        train_start = 1'b1;
        tick(1);
        train_start = 1'b0;
        for (int i = 0; i < 2000 && locked !== '1; i++) begin
            tick(1);
        end
    endtask

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        deser_valid = 1'b1;
        slip_enable = 1'b1;
        overflow_clear = 1'b0;
        train_start = 1'b0;
        user_ready = 1'b1;
        slip_from_pin = '0;
        slip_pin = '0;
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        for (int g = 0; g < N; g++) begin
            deser_word[g*W +: W] = rot(OFS[g]);
        end
        tick(2);
        nrst = 1'b1;
        check(16'(locked), 16'h0000);
        check(16'(slip_count), 16'h0000);
        train();
        check(16'(locked), 16'h000f);
        for (int g = 0; g < N; g++) begin
            check(cnt(g), 16'(OFS[g]));
            check(uw(g), 16'(PAT));
        end
        slip_enable = 1'b0;
        slip_from_pin = 4'h1;
        pin_pulse(2);
        tick(30);
        check(cnt(0), 16'(OFS[0]));
        check(uw(0), 16'(PAT));
        slip_enable = 1'b1;
        pin_pulse(2);
        tick(30);
        check(cnt(0), 16'(OFS[0] + 1));
        check(uw(0), 16'(rot(W - 1)));
        check(cnt(1), 16'(OFS[1]));
        for (int k = 0; k < W - 1; k++) begin
            pin_pulse(2);
        end
        tick(30);
        check(cnt(0), 16'(OFS[0]));
        check(uw(0), 16'(PAT));
        pin_pulse(8);
        tick(30);
        check(cnt(0), 16'(OFS[0] + 1));
        slip_from_pin = 4'h0;
        train();
        check(16'(locked), 16'h000f);
        check(cnt(0), 16'(OFS[0]));
        user_ready = 1'b0;
        tick(30);
        check(16'(deser_ready), 16'h0000);
        check(16'(user_valid), 16'h0000);
        overflow_clear = 1'b1;
        tick(1);
        check(16'(overflow), 16'h0001);
        overflow_clear = 1'b0;
        deser_valid = 1'b0;
        user_ready = 1'b1;
        tick(30);
        check(16'(realign_if_i.word_valid), 16'h0000);
        check(16'(deser_ready), 16'h0001);
        overflow_clear = 1'b1;
        tick(1);
        overflow_clear = 1'b0;
        check(16'(overflow), 16'h0000);
        deser_valid = 1'b1;
        tick(30);
        check(uw(2), 16'(PAT));
        check(16'(user_valid), 16'h0001);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        check(16'(slip_count), 16'h0000);
        check(16'(locked), 16'h0000);
        stop_test();
    end
endmodule
